/* core/tpr_pkg.sv */
// Shared constants and carrier types for the tank pump relay controller.
// Assumes a single 100 MHz clock domain.
package tpr_pkg;
  localparam int tpr_clk_hz = 100_000_000;
  localparam int tpr_hold_s = 3;
  localparam int tpr_pause_s = 60;
  localparam int tpr_run_default_min = 3;
  localparam int tpr_run_min_min = 1;
  localparam int tpr_run_max_min = 5;
  localparam int tpr_sec_per_min = 60;
  localparam int tpr_hyst_bars = 6;
  localparam int tpr_lvl_w = 4;
  localparam int tpr_tanks = 4;
  localparam logic [2:0] tpr_sw_min = 3'h2;
  localparam logic [2:0] tpr_sw_max = 3'h5;
  localparam int tpr_name_len = 8;
  localparam logic [4:0] tpr_char_max = 5'h1a;
  localparam int tpr_vol_digits = 5;
  localparam logic [3:0] tpr_digit_max = 4'h9;
  localparam logic [3:0] tpr_lvl_empty = 4'h0;
  localparam logic [3:0] tpr_lvl_full = 4'hf;

  typedef enum logic [1:0] {tpr_grey, tpr_black, tpr_fuel, tpr_fresh} tpr_kind_type;

  typedef struct packed {
    logic backlight;
    logic scroll;
    logic pump;
  } tpr_keys_type;

  typedef struct packed {
    logic valid;
    logic [2:0] switch_no;
    logic [tpr_name_len*5-1:0] name;
    tpr_kind_type kind;
    logic [3:0] alarm_on;
    logic audible;
    logic vol_en;
    logic vol_gallons;
    logic [tpr_vol_digits*4-1:0] volume;
    logic [3:0] relay_on;
    logic [3:0] relay_off;
    logic [3:0] pump_stop;
    logic special;
    logic [2:0] run_min;
  } tpr_tank_type;

  typedef struct packed {
    logic alarm_audible;
    logic alarm_visual;
    logic relay1;
    logic relay2;
    logic pump;
  } tpr_outs_type;
endpackage

/* core/tpr_controller.sv */
// Keypad set-up menu and level-driven alarm, relay and pump control for one master display.
// Assumes debounced keypad pins and same-clock level samples with a one-cycle valid strobe.
// Contract
// - Holding backlight and scroll together for 3 s enters program mode.
// - Exit commits edited settings, leaves program mode, resumes monitoring.
// - Scroll/backlight step remote unit switch number; pump confirms it.
// - Name edit: backlight moves cursor, scroll cycles letter, pump accepts.
// - After type, keys step levels; pump stores alarm-on level.
// - Scroll enables audible alarm, backlight disables; disabled gives bell only.
// - Volume selects litres or gallons; digits entered one by one with pump.
// - Relay set-up stores on then off level; marker shows on level.
// - Grey/black pump stop level settable, defaults to empty.
// - Special pump: timed run, one minute pause, level-scaled reruns until empty.
// - Special run time defaults 3 minutes, or 1 to 5 chosen.
// - Special pump off disables and returns to menu directly.
// - Erase clears settings of scroll-selected tank on pump, back to menu.
// - Grey/black: alarm and relay 1 on at on point; relay 1 off at off point; pump mutes.
// - Grey/black: pump after mute runs pump and relay 2 until empty or press.
// - Fuel: pump and relay 2 on at low point, off at full.
// - Fuel: pump key starts pump anytime; stops at full or press.
// - Fuel/fresh: alarm and relay 1 on at low, off 6 bars above.
// - Fresh: pump press energises pump and relay 2; off at full or press.
`timescale 1ns/1ps
module tpr_controller #(
  parameter int hold_cycles = tpr_pkg::tpr_clk_hz * tpr_pkg::tpr_hold_s,
  parameter int sec_cycles = tpr_pkg::tpr_clk_hz
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Keypad levels
  input wire tpr_pkg::tpr_keys_type keys,
  // Level samples from remote units
  input wire logic sample_valid,
  input wire logic [2:0] sample_switch,
  input wire logic [3:0] sample_level,
  // Status
  output logic program_mode,
  output logic [3:0] edit_level,
  output logic [3:0] relay_marker,
  output logic [2:0] edit_switch,
  output logic [2:0] name_cursor,
  output logic [2:0] digit_cursor,
  // Outputs per tank slot
  output tpr_pkg::tpr_outs_type [tpr_pkg::tpr_tanks-1:0] outs
);
  import tpr_pkg::*;

  typedef enum {
    st_monitor, st_menu, st_switch, st_name, st_type, st_alarm, st_audible, st_vol_en,
    st_vol_unit, st_vol_digit, st_exit, st_relay_on, st_relay_off, st_stop_sel, st_stop,
    st_spec_sel, st_spec_on, st_spec_time, st_spec_set, st_erase, st_relay_sel
  } tpr_state_type;

  typedef enum logic [2:0] {
    m_program, m_relay, m_stop, m_special, m_erase, m_exit
  } tpr_menu_type;

  function automatic logic [1:0] slot_of(input logic [2:0] sw);
    slot_of = 2'(sw - tpr_sw_min);
  endfunction

  function automatic logic in_range(input logic [2:0] sw);
    in_range = (sw >= tpr_sw_min) && (sw <= tpr_sw_max);
  endfunction

  function automatic logic [3:0] step_lvl(input logic [3:0] v, input logic up);
    if (up) begin
      step_lvl = (v == tpr_lvl_full) ? v : 4'(v + 4'h1);
    end else begin
      step_lvl = (v == tpr_lvl_empty) ? v : 4'(v - 4'h1);
    end
  endfunction

  localparam tpr_tank_type blank_tank = '{default: '0, kind: tpr_grey, pump_stop: tpr_lvl_empty,
    run_min: 3'(tpr_run_default_min)};
  localparam logic [2:0] last_digit = 3'(tpr_vol_digits - 1);
  localparam logic [2:0] last_char = 3'(tpr_name_len - 1);
  localparam logic [2:0] run_default = 3'(tpr_run_default_min);
  localparam logic [2:0] run_lo = 3'(tpr_run_min_min);
  localparam logic [2:0] run_hi = 3'(tpr_run_max_min);

  // Key edges; keypad pins are asynchronous, so two stages come first
  tpr_keys_type keys_m, keys_s, keys_q;
  logic press_b, press_s, press_p;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      keys_m <= '0;
      keys_s <= '0;
      keys_q <= '0;
    end else begin
      keys_m <= keys;
      keys_s <= keys_m;
      keys_q <= keys_s;
    end
  end
  assign press_b = keys_s.backlight & ~keys_q.backlight;
  assign press_s = keys_s.scroll & ~keys_q.scroll;
  assign press_p = keys_s.pump & ~keys_q.pump;

  // Combined hold timer
  logic [31:0] hold_cnt;
  logic hold_done;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_cnt <= '0;
    end else if (keys_s.backlight && keys_s.scroll && !program_mode) begin
      if (hold_cnt != 32'(hold_cycles)) begin
        hold_cnt <= 32'(hold_cnt + 32'h1);
      end
    end else begin
      hold_cnt <= '0;
    end
  end
  assign hold_done = (hold_cnt == 32'(hold_cycles - 1));

  // Working copy edited in program mode, committed copy drives outputs
  tpr_tank_type work [tpr_tanks];
  tpr_tank_type live [tpr_tanks];
  tpr_state_type state;
  tpr_menu_type menu;
  logic [1:0] cur;
  tpr_tank_type t;
  assign t = work[cur];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= st_monitor;
      menu <= m_program;
      cur <= '0;
      edit_switch <= tpr_sw_min;
      edit_level <= '0;
      relay_marker <= '0;
      name_cursor <= '0;
      digit_cursor <= '0;
      program_mode <= 1'b0;
      for (int i = 0; i < tpr_tanks; i++) begin
        work[i] <= blank_tank;
        live[i] <= blank_tank;
      end
    end else begin
      case (state)
        st_monitor: if (hold_done) begin
          state <= st_menu;
          program_mode <= 1'b1;
          menu <= m_program;
        end
        st_menu: begin
          if (press_s) begin
            menu <= (menu == m_exit) ? m_program : tpr_menu_type'(menu + 3'h1);
          end else if (press_p) begin
            case (menu)
              m_program: state <= st_switch;
              m_relay: state <= st_relay_sel;
              m_stop: state <= st_stop_sel;
              m_special: state <= st_spec_sel;
              m_erase: state <= st_erase;
              default: state <= st_exit;
            endcase
          end
        end
        st_switch, st_relay_sel, st_stop_sel, st_spec_sel, st_erase: begin
          // Only switch positions two to five exist on the network
          if (press_s) begin
            edit_switch <= (edit_switch == tpr_sw_max) ? tpr_sw_min : 3'(edit_switch + 3'h1);
          end else if (press_b) begin
            edit_switch <= (edit_switch == tpr_sw_min) ? tpr_sw_max : 3'(edit_switch - 3'h1);
          end else if (press_p && in_range(edit_switch)) begin
            cur <= slot_of(edit_switch);
            case (state)
              st_switch: begin
                state <= st_name;
                work[slot_of(edit_switch)].valid <= 1'b1;
                work[slot_of(edit_switch)].switch_no <= edit_switch;
                name_cursor <= '0;
              end
              st_stop_sel: begin
                state <= st_stop;
                edit_level <= work[slot_of(edit_switch)].pump_stop;
              end
              st_spec_sel: state <= st_spec_on;
              st_relay_sel: begin
                state <= st_relay_on;
                edit_level <= work[slot_of(edit_switch)].relay_on;
              end
              default: begin
                work[slot_of(edit_switch)] <= blank_tank;
                state <= st_menu;
              end
            endcase
          end
        end
        st_name: begin
          if (press_b) begin
            name_cursor <= (name_cursor == last_char) ? '0 : 3'(name_cursor + 3'h1);
          end else if (press_s) begin
            work[cur].name[name_cursor*5 +: 5] <=
              (t.name[name_cursor*5 +: 5] == tpr_char_max) ? 5'h00 :
              5'(t.name[name_cursor*5 +: 5] + 5'h01);
          end else if (press_p) begin
            state <= st_type;
          end
        end
        st_type: begin
          if (press_s || press_b) begin
            work[cur].kind <= tpr_kind_type'(2'(t.kind + (press_s ? 2'h1 : 2'h3)));
          end else if (press_p) begin
            state <= st_alarm;
            edit_level <= t.alarm_on;
          end
        end
        st_alarm, st_relay_on, st_relay_off, st_stop: begin
          if (press_s || (press_b && state != st_stop)) begin
            edit_level <= step_lvl(edit_level, press_s);
          end else if (press_p) begin
            case (state)
              st_alarm: begin
                work[cur].alarm_on <= edit_level;
                state <= st_audible;
              end
              st_relay_on: begin
                work[cur].relay_on <= edit_level;
                relay_marker <= edit_level;
                state <= st_relay_off;
              end
              st_relay_off: begin
                work[cur].relay_off <= edit_level;
                state <= st_menu;
              end
              default: begin
                work[cur].pump_stop <= edit_level;
                state <= st_menu;
              end
            endcase
          end
        end
        st_audible: begin
          if (press_s || press_b) begin
            work[cur].audible <= press_s;
            state <= st_vol_en;
          end
        end
        st_vol_en: begin
          if (press_s) begin
            work[cur].vol_en <= 1'b1;
            state <= st_vol_unit;
          end else if (press_b) begin
            work[cur].vol_en <= 1'b0;
            state <= st_exit;
          end
        end
        st_vol_unit: begin
          if (press_s || press_b) begin
            work[cur].vol_gallons <= press_b;
            digit_cursor <= '0;
            state <= st_vol_digit;
          end
        end
        st_vol_digit: begin
          if (press_s) begin
            work[cur].volume[digit_cursor*4 +: 4] <=
              (t.volume[digit_cursor*4 +: 4] == tpr_digit_max) ? 4'h0 :
              4'(t.volume[digit_cursor*4 +: 4] + 4'h1);
          end else if (press_b) begin
            work[cur].volume[digit_cursor*4 +: 4] <=
              (t.volume[digit_cursor*4 +: 4] == 4'h0) ? tpr_digit_max :
              4'(t.volume[digit_cursor*4 +: 4] - 4'h1);
          end else if (press_p) begin
            if (digit_cursor == last_digit) begin
              state <= st_exit;
            end else begin
              digit_cursor <= 3'(digit_cursor + 3'h1);
            end
          end
        end
        st_exit: begin
          if (press_s) begin
            state <= st_menu;
            menu <= m_program;
          end else if (press_b || (menu == m_exit && press_p)) begin
            for (int i = 0; i < tpr_tanks; i++) begin
              live[i] <= work[i];
            end
            state <= st_monitor;
            program_mode <= 1'b0;
          end
        end
        st_spec_on: begin
          if (press_s) begin
            work[cur].special <= 1'b0;
            state <= st_menu;
          end else if (press_b) begin
            work[cur].special <= 1'b1;
            state <= st_spec_time;
          end
        end
        st_spec_time: begin
          if (press_b) begin
            work[cur].run_min <= run_default;
            state <= st_menu;
          end else if (press_s) begin
            work[cur].run_min <= run_lo;
            state <= st_spec_set;
          end
        end
        st_spec_set: begin
          if (press_s) begin
            work[cur].run_min <= (t.run_min >= run_hi) ? run_lo : 3'(t.run_min + 3'h1);
          end else if (press_p) begin
            state <= st_menu;
          end
        end
        default: state <= st_monitor;
      endcase
    end
  end

  // One-second tick shared by all special pump timers
  logic [31:0] sec_cnt;
  logic sec_tick;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sec_cnt <= '0;
    end else begin
      sec_cnt <= sec_tick ? '0 : 32'(sec_cnt + 32'h1);
    end
  end
  assign sec_tick = (sec_cnt == 32'(sec_cycles - 1));

  // Monitoring; scroll steps the displayed tank, the one the pump key targets
  logic [1:0] view;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      view <= '0;
    end else if (!program_mode && press_s) begin
      view <= 2'(view + 2'h1);
    end
  end

  genvar g;
  generate
    for (g = 0; g < tpr_tanks; g++) begin : tank
      logic [3:0] lvl;
      logic alarm, muted, relay1, pump_on, pausing;
      logic [9:0] secs;
      logic hit;
      tpr_tank_type c;
      assign c = live[g];
      assign hit = sample_valid && sample_switch == 3'(g + tpr_sw_min);
      // Pump key belongs to the displayed tank only
      logic key;
      assign key = press_p && !program_mode && view == 2'(g) && c.valid;

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          lvl <= '0;
          alarm <= 1'b0;
          muted <= 1'b0;
          relay1 <= 1'b0;
        end else begin
          if (hit) begin
            lvl <= sample_level;
          end
          if (!c.valid) begin
            alarm <= 1'b0;
            relay1 <= 1'b0;
            muted <= 1'b0;
          end else if (hit && (c.kind == tpr_fuel || c.kind == tpr_fresh)) begin
            if (sample_level <= c.alarm_on) begin
              alarm <= 1'b1;
              relay1 <= 1'b1;
            end else if (5'(sample_level) >= 5'(c.alarm_on) + 5'(tpr_hyst_bars)) begin
              alarm <= 1'b0;
              relay1 <= 1'b0;
              muted <= 1'b0;
            end
          end else if (hit) begin
            if (sample_level >= c.alarm_on) begin
              alarm <= 1'b1;
            end else begin
              alarm <= 1'b0;
              muted <= 1'b0;
            end
            if (sample_level >= c.relay_on) begin
              relay1 <= 1'b1;
            end else if (sample_level <= c.relay_off) begin
              relay1 <= 1'b0;
            end
          end
          if (key && alarm && !muted) begin
            muted <= 1'b1;
          end
        end
      end

      // Pump: a key press that mutes never also toggles the pump
      logic mute_press, drain;
      assign mute_press = key && alarm && !muted;
      assign drain = c.kind == tpr_grey || c.kind == tpr_black;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          pump_on <= 1'b0;
          pausing <= 1'b0;
          secs <= '0;
        end else if (!c.valid) begin
          pump_on <= 1'b0;
          pausing <= 1'b0;
          secs <= '0;
        end else if (key && !mute_press) begin
          pump_on <= ~pump_on;
          pausing <= 1'b0;
          secs <= (drain && c.special) ? 10'(c.run_min * tpr_sec_per_min) : '0;
        end else if (drain) begin
          if (c.special && pump_on) begin
            // Level reads wrong while running, so only timers decide
            if (sec_tick && secs != '0) begin
              secs <= 10'(secs - 10'h1);
            end else if (secs == '0 || (sec_tick && secs == 10'h1)) begin
              if (!pausing) begin
                pausing <= 1'b1;
                secs <= 10'(tpr_pause_s);
              end else if (lvl <= c.pump_stop) begin
                pump_on <= 1'b0;
                pausing <= 1'b0;
              end else begin
                pausing <= 1'b0;
                secs <= 10'(lvl * c.run_min * 4'h4);
              end
            end
          end else if (hit && pump_on && sample_level <= c.pump_stop) begin
            pump_on <= 1'b0;
          end
        end else if (hit) begin
          if (sample_level >= tpr_lvl_full) begin
            pump_on <= 1'b0;
          end else if (c.kind == tpr_fuel && sample_level <= c.alarm_on) begin
            pump_on <= 1'b1;
          end
        end
      end

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          outs[g] <= '0;
        end else begin
          outs[g].alarm_audible <= alarm && !muted && c.audible;
          outs[g].alarm_visual <= alarm;
          outs[g].relay1 <= relay1;
          outs[g].relay2 <= pump_on && !pausing;
          outs[g].pump <= pump_on && !pausing;
        end
      end
    end
  endgenerate
endmodule

/* verification/tpr_checker_sva.sv */
// Port checker for the tank pump relay controller.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ps
module tpr_checker #(
  parameter int hold_cycles = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs
  input wire tpr_pkg::tpr_keys_type keys,
  input wire logic sample_valid,
  // Outputs
  input wire logic program_mode,
  input wire logic [2:0] edit_switch,
  input wire tpr_pkg::tpr_outs_type [tpr_pkg::tpr_tanks-1:0] outs
);
  import tpr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Counts consecutive cycles of both keys held; saturates instead of wrapping
  logic [15:0] hold_cnt;
  // Exit key passes two sync stages and the edge stage before the mode falls
  sequence s_exit_press;
    $past(keys.backlight, 3) || $past(keys.pump, 3);
  endsequence
  // Output register lags the sample by two stages
  sequence s_fresh_sample;
    $past(sample_valid, 2) || $past(sample_valid, 3);
  endsequence
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_cnt <= 16'h0000;
    end else if (!(keys.backlight && keys.scroll)) begin
      hold_cnt <= 16'h0000;
    end else if (hold_cnt != 16'hffff) begin
      hold_cnt <= hold_cnt + 16'h0001;
    end
  end
  a_prog_enter: assert property (hold_cnt == hold_cycles + 3 |-> program_mode)
    else $error("program mode not entered after hold");
  a_prog_early: assert property ($rose(program_mode) |-> $past(hold_cnt) >= hold_cycles + 1)
    else $error("program mode entered too early");
  a_exit_key: assert property ($fell(program_mode) |-> s_exit_press)
    else $error("program mode left without exit key");
  a_switch_range: assert property (edit_switch >= tpr_sw_min && edit_switch <= tpr_sw_max)
    else $error("switch number out of range");
  for (genvar i = 0; i < tpr_tanks; i++) begin : g_slot
    a_bell_only: assert property (outs[i].alarm_audible |-> outs[i].alarm_visual)
      else $error("audible alarm without bell");
    a_relay2_pump: assert property (outs[i].relay2 == outs[i].pump)
      else $error("relay 2 and pump disagree");
    a_alarm_sample: assert property ($rose(outs[i].alarm_visual) |-> s_fresh_sample)
      else $error("alarm rose without a sample");
    a_relay_sample: assert property ($rose(outs[i].relay1) |-> s_fresh_sample)
      else $error("relay 1 rose without a sample");
  end
endmodule
bind tpr_controller tpr_checker #(.hold_cycles(hold_cycles)) u_chk (
  .clk(clk),
  .reset(reset),
  .keys(keys),
  .sample_valid(sample_valid),
  .program_mode(program_mode),
  .edit_switch(edit_switch),
  .outs(outs)
);

/* verification/tpr_remote_units.sv */
// Behavioural remote tank units sending level samples.
// Assumes the caller enters send between clock edges.
`timescale 1ns/1ps
module tpr_remote_units (
  // Clock
  input wire logic clk,
  // Sample lines
  output logic sample_valid,
  output logic [2:0] sample_switch,
  output logic [3:0] sample_level
);
  initial begin
    sample_valid = 1'b0;
    sample_switch = 3'h2;
    sample_level = 4'h0;
  end
  task automatic send(input logic [2:0] sw, input logic [3:0] lvl);
    if (sw >= 3'h2 && sw <= 3'h5) begin
      @(negedge clk);
      sample_valid = 1'b1;
      sample_switch = sw;
      sample_level = lvl;
      @(negedge clk);
      sample_valid = 1'b0;
      // Stale lines must not look like a valid repeat
      sample_switch = ~sw;
      sample_level = ~lvl;
    end
  endtask
endmodule

/* verification/tank_pump_relay_controller_tb_top.sv */
// Self-checking bench of the tank pump relay controller.
// Assumes the remote unit model and the bound checker are compiled first.
`timescale 1ns/1ps
module tank_pump_relay_controller_tb_top;
  import tpr_pkg::*;
  localparam int hold = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  tpr_keys_type keys = '0;
  logic sample_valid;
  logic [2:0] sample_switch;
  logic [3:0] sample_level;
  logic program_mode;
  logic [3:0] edit_level;
  logic [3:0] relay_marker;
  logic [2:0] edit_switch;
  logic [2:0] name_cursor;
  logic [2:0] digit_cursor;
  tpr_outs_type [tpr_tanks-1:0] outs;
  int fails = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  tpr_remote_units units (
    .clk(clk),
    .sample_valid(sample_valid),
    .sample_switch(sample_switch),
    .sample_level(sample_level)
  );
  tpr_controller #(.hold_cycles(hold), .sec_cycles(5)) uut (
    .clk(clk),
    .reset(reset),
    .keys(keys),
    .sample_valid(sample_valid),
    .sample_switch(sample_switch),
    .sample_level(sample_level),
    .program_mode(program_mode),
    .edit_level(edit_level),
    .relay_marker(relay_marker),
    .edit_switch(edit_switch),
    .name_cursor(name_cursor),
    .digit_cursor(digit_cursor),
    .outs(outs)
  );
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic press(logic [2:0] k);
    @(negedge clk);
    keys = tpr_keys_type'(k);
    @(negedge clk);
    keys = '0;
    repeat (3) @(negedge clk);
  endtask
  task automatic feed(logic [2:0] sw, logic [3:0] lvl);
    units.send(sw, lvl);
    repeat (4) @(negedge clk);
  endtask
  task automatic enter_prog();
    @(negedge clk);
    keys = tpr_keys_type'(3'h6);
    repeat (hold - 3) @(negedge clk);
    check("early program_mode", 1'b0, program_mode);
    repeat (8) @(negedge clk);
    check("program_mode", 1'b1, program_mode);
    keys = '0;
    repeat (3) @(negedge clk);
  endtask
  task automatic set_level(logic [3:0] t);
    for (int n = 0; n < 20 && edit_level !== t; n++) begin
      press(edit_level < t ? 3'h2 : 3'h4);
    end
    check("edit_level", t, edit_level);
  endtask
  task automatic set_switch(logic [2:0] sw);
    logic [2:0] e;
    e = (edit_switch == 3'h5) ? 3'h2 : edit_switch + 3'h1;
    press(3'h2);
    check("edit_switch step", e, edit_switch);
    for (int n = 0; n < 8 && edit_switch !== sw; n++) begin
      press(3'h2);
    end
    press(3'h1);
  endtask
  task automatic program_tank(logic [2:0] sw, int kinds, logic [3:0] lvl, logic aud, logic vol);
    logic [2:0] c;
    enter_prog();
    press(3'h1);
    set_switch(sw);
    c = name_cursor;
    press(3'h4);
    check("name_cursor", c + 3'h1, name_cursor);
    press(3'h1);
    repeat (kinds) press(3'h2);
    press(3'h1);
    set_level(lvl);
    press(3'h1);
    press(aud ? 3'h2 : 3'h4);
    if (vol) begin
      repeat (3) press(3'h2);
      press(3'h1);
      check("digit_cursor", 3'h1, digit_cursor);
      repeat (4) press(3'h1);
    end else begin
      press(3'h4);
    end
    feed(sw, 4'hf);
    check("uncommitted outs", 5'h00, outs[sw - 3'h2]);
    press(3'h4);
    check("program_mode exit", 1'b0, program_mode);
  endtask
  task automatic test_grey();
    program_tank(3'h2, 0, 4'ha, 1'b1, 1'b0);
    // The combined hold also counts as a tank scroll; wrap back to slot 0
    repeat (3) press(3'h2);
    feed(3'h2, 4'h9);
    check("grey below", 2'h0, {outs[0].alarm_audible, outs[0].alarm_visual});
    feed(3'h2, 4'ha);
    check("grey alarm", 2'h3, {outs[0].alarm_audible, outs[0].alarm_visual});
    press(3'h1);
    check("grey muted", 2'h1, {outs[0].alarm_audible, outs[0].alarm_visual});
    press(3'h1);
    check("grey pump on", 2'h3, {outs[0].relay2, outs[0].pump});
    feed(3'h2, 4'h3);
    check("grey above stop", 1'b1, outs[0].pump);
    press(3'h1);
    check("grey key off", 1'b0, outs[0].pump);
    press(3'h1);
    feed(3'h2, 4'h0);
    // Relay 1 stays on: its on point is still the blank empty level
    check("grey empty", 5'h04, outs[0] & 5'h17);
    $display("test grey done");
  endtask
  task automatic test_fuel();
    program_tank(3'h3, 2, 4'h4, 1'b0, 1'b1);
    feed(3'h3, 4'h8);
    check("fuel high", 5'h00, outs[1]);
    feed(3'h3, 4'h4);
    check("fuel low", 5'h0f, outs[1]);
    feed(3'h3, 4'h9);
    check("fuel hysteresis", 5'h0f, outs[1]);
    feed(3'h3, 4'ha);
    check("fuel clear", 5'h03, outs[1]);
    feed(3'h3, 4'hf);
    check("fuel full", 5'h00, outs[1]);
    // Full turn of the tank view lands on slot 1 again
    repeat (4) press(3'h2);
    feed(3'h3, 4'hc);
    press(3'h1);
    check("fuel key start", 5'h03, outs[1]);
    press(3'h1);
    check("fuel key stop", 5'h00, outs[1]);
    $display("test fuel done");
  endtask
  task automatic test_relay();
    enter_prog();
    press(3'h2);
    press(3'h1);
    set_switch(3'h2);
    set_level(4'hc);
    press(3'h1);
    check("relay_marker", 4'hc, relay_marker);
    set_level(4'h5);
    press(3'h1);
    feed(3'h2, 4'h3);
    check("still in set-up", 1'b1, program_mode);
    check("old relay points", 1'b1, outs[0].relay1);
    repeat (4) press(3'h2);
    press(3'h1);
    press(3'h1);
    check("menu exit", 1'b0, program_mode);
    feed(3'h2, 4'h3);
    check("relay off point", 1'b0, outs[0].relay1);
    feed(3'h2, 4'hc);
    check("relay on point", 1'b1, outs[0].relay1);
    $display("test relay done");
  endtask
  task automatic test_erase();
    enter_prog();
    repeat (4) press(3'h2);
    press(3'h1);
    set_switch(3'h3);
    press(3'h2);
    press(3'h1);
    press(3'h1);
    check("erase exit", 1'b0, program_mode);
    feed(3'h3, 4'h4);
    check("erased outs", 5'h00, outs[1]);
    $display("test erase done");
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    test_grey();
    test_fuel();
    test_relay();
    test_erase();
    stop_test();
  end
  // Whole run needs under a thousand cycles; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
